// ==== mst_pkg.sv ====
package mst_pkg;

    // Decay mode codes shared by translator and chopper
    typedef enum logic [1:0] {
        MST_DECAY_SLOW,
        MST_DECAY_FAST,
        MST_DECAY_MIXED
    } mst_decay_t;

    localparam int             MST_CLK_PERIOD_PS = 4000;
    localparam int             MST_BLANK_NS      = 950;
    localparam int             MST_OFF_US        = 38;
    localparam int             MST_FAST_US       = 12;
    // Least times round up, so blanking never ends early
    localparam int             MST_BLANK_CYC     = (MST_BLANK_NS * 1000 + MST_CLK_PERIOD_PS - 1) / MST_CLK_PERIOD_PS;
    localparam int             MST_OFF_CYC       = (MST_OFF_US * 1000000 + MST_CLK_PERIOD_PS - 1) / MST_CLK_PERIOD_PS;
    localparam int             MST_FAST_CYC      = (MST_FAST_US * 1000000 + MST_CLK_PERIOD_PS - 1) / MST_CLK_PERIOD_PS;

    localparam logic [5:0]     MST_HOME_POS      = 6'h08;
    localparam logic [7:0]     MST_HOME_LEVEL    = 8'hB4;
    localparam logic [5:0]     MST_INC_FULL      = 6'h10;
    localparam logic [5:0]     MST_INC_HALF      = 6'h08;
    localparam logic [5:0]     MST_INC_QUARTER   = 6'h04;
    localparam logic [5:0]     MST_INC_SIXTEENTH = 6'h01;

    localparam logic [7:0]     MST_REG_OFF       = 8'h00;
    localparam logic [7:0]     MST_REG_BLANK     = 8'h04;
    localparam logic [7:0]     MST_REG_FAST      = 8'h08;
    localparam logic [7:0]     MST_REG_STATUS    = 8'h0C;

    localparam int             MST_SYNC_W        = 18;

    // Gate vector layout: {sourceA, sinkA, sourceB, sinkB}
    localparam int             MST_G_SRC_A       = 3;
    localparam int             MST_G_SNK_A       = 2;
    localparam int             MST_G_SRC_B       = 1;
    localparam int             MST_G_SNK_B       = 0;

    // Quarter-wave current table in 1/16 step units, full scale 255
    function automatic logic [7:0] mst_sine(input logic [4:0] idx);
        logic [7:0] v;
        v = 8'h00;
        case (idx)
            5'd0:  v = 8'h00;
            5'd1:  v = 8'h19;
            5'd2:  v = 8'h32;
            5'd3:  v = 8'h4A;
            5'd4:  v = 8'h62;
            5'd5:  v = 8'h78;
            5'd6:  v = 8'h8E;
            5'd7:  v = 8'hA2;
            5'd8:  v = 8'hB4;
            5'd9:  v = 8'hC5;
            5'd10: v = 8'hD4;
            5'd11: v = 8'hE1;
            5'd12: v = 8'hEC;
            5'd13: v = 8'hF4;
            5'd14: v = 8'hFA;
            5'd15: v = 8'hFE;
            default: v = 8'hFF;
        endcase
        return v;
    endfunction : mst_sine

endpackage : mst_pkg

// ==== mst_chop_if.sv ====
`timescale 1ns/1ps
interface mst_chop_if;
    import mst_pkg::*;
    logic        enable;
    logic        stepEvent;
    logic        polarity;
    logic        tripRaw;
    logic        zeroCur;
    logic        rectDisable;
    mst_decay_t  decay;
    logic [15:0] offCycles;
    logic [15:0] blankCycles;
    logic [15:0] fastCycles;
    logic [3:0]  gates;

    modport ctrl (output enable, stepEvent, polarity, tripRaw, zeroCur, rectDisable, decay,
                  offCycles, blankCycles, fastCycles, input gates);
    modport chop (input enable, stepEvent, polarity, tripRaw, zeroCur, rectDisable, decay,
                  offCycles, blankCycles, fastCycles, output gates);
endinterface : mst_chop_if

// ==== mst_chopper.sv ====
`timescale 1ns/1ps
module mst_chopper
    import mst_pkg::*;
(
    input  wire logic clk,
    input  wire logic nrst,
    mst_chop_if.chop  cif
);

    typedef enum logic [1:0] {ST_ON, ST_FAST, ST_SLOW} mst_chop_state_t;

    mst_chop_state_t stateQ;
    mst_chop_state_t stateD;
    logic [15:0]     offCntQ;
    logic [15:0]     blankCntQ;
    logic            enablePrevQ;
    logic            tripped;
    logic            switchEvent;

    assign tripped     = cif.tripRaw && (blankCntQ == 16'h0000) && (stateQ == ST_ON);
    assign switchEvent = (stateD != stateQ) || cif.stepEvent || (cif.enable != enablePrevQ);

    always_comb begin
        stateD = stateQ;
        if (!cif.enable) begin
            stateD = ST_ON;
        end else begin
            unique case (stateQ)
                ST_ON: begin
                    if (tripped) begin
                        stateD = (cif.decay == MST_DECAY_SLOW) ? ST_SLOW : ST_FAST;
                    end
                end
                ST_FAST: begin
                    if (offCntQ <= 16'h0001) begin
                        stateD = ST_ON;
                    end else if (cif.decay == MST_DECAY_MIXED &&
                                 (cif.offCycles - offCntQ) >= cif.fastCycles) begin
                        stateD = ST_SLOW;
                    end
                end
                ST_SLOW: begin
                    if (offCntQ <= 16'h0001) begin
                        stateD = ST_ON;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            stateQ      <= ST_ON;
            enablePrevQ <= 1'b0;
        end else begin
            stateQ      <= stateD;
            enablePrevQ <= cif.enable;
        end
    end

    // One-shot off timer, loaded on every turn-off
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            offCntQ <= 16'h0000;
        end else if (stateQ == ST_ON && stateD != ST_ON) begin
            offCntQ <= cif.offCycles;
        end else if (offCntQ != 16'h0000) begin
            offCntQ <= offCntQ - 16'h0001;
        end
    end

    // Blanking restarts on any switching event, rejecting recovery spikes
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            blankCntQ <= 16'h0000;
        end else if (switchEvent) begin
            blankCntQ <= cif.blankCycles;
        end else if (blankCntQ != 16'h0000) begin
            blankCntQ <= blankCntQ - 16'h0001;
        end
    end

    // Gate drive; sync rectification drops at zero current so current never reverses
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cif.gates <= 4'h0;
        end else if (!cif.enable) begin
            cif.gates <= 4'h0;
        end else begin
            cif.gates <= 4'h0;
            unique case (stateD)
                ST_ON: begin
                    if (cif.polarity) begin
                        cif.gates[MST_G_SRC_A] <= 1'b1;
                        cif.gates[MST_G_SNK_B] <= 1'b1;
                    end else begin
                        cif.gates[MST_G_SRC_B] <= 1'b1;
                        cif.gates[MST_G_SNK_A] <= 1'b1;
                    end
                end
                ST_SLOW: begin
                    // Sources off, the sink stays on
                    cif.gates[MST_G_SNK_B] <= cif.polarity;
                    cif.gates[MST_G_SNK_A] <= !cif.polarity;
                    if (!cif.rectDisable && !cif.zeroCur) begin
                        cif.gates[MST_G_SNK_A] <= 1'b1;
                        cif.gates[MST_G_SNK_B] <= 1'b1;
                    end
                end
                ST_FAST: begin
                    // All off; rectification turns on the opposite diagonal
                    if (!cif.rectDisable && !cif.zeroCur) begin
                        if (cif.polarity) begin
                            cif.gates[MST_G_SRC_B] <= 1'b1;
                            cif.gates[MST_G_SNK_A] <= 1'b1;
                        end else begin
                            cif.gates[MST_G_SRC_A] <= 1'b1;
                            cif.gates[MST_G_SNK_B] <= 1'b1;
                        end
                    end
                end
            endcase
        end
    end

endmodule : mst_chopper

// ==== mst_translator_top.sv ====
`timescale 1ns/1ps
module mst_translator_top
    import mst_pkg::*;
#(
    parameter int OFF_CYC_DEFAULT   = MST_OFF_CYC,
    parameter int FAST_CYC_DEFAULT  = MST_FAST_CYC,
    parameter int BLANK_CYC_DEFAULT = MST_BLANK_CYC
) (
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        step,
    input  wire logic        dir,
    input  wire logic        resolution_sel_lo,
    input  wire logic        resolution_sel_hi,
    input  wire logic        resetN,
    input  wire logic        sleepN,
    input  wire logic        enableN,
    input  wire logic [1:0]  decay_select,
    input  wire logic        rectify_disable,
    input  wire logic        sinkGateSupplyFault,
    input  wire logic        sourceGateSupplyFault,
    input  wire logic        overTemp,
    input  wire logic        logic_supply_lockout,
    input  wire logic [1:0]  chopTrip,
    input  wire logic [1:0]  zeroCurrent,
    output logic [3:0]       gatesPhase1,
    output logic [3:0]       gatesPhase2,
    output logic [7:0]       levelPhase1,
    output logic [7:0]       levelPhase2,
    output logic             polarityPhase1,
    output logic             polarityPhase2,
    output logic             chargePumpEn,
    output logic             home
);

    // Three-stage synchronisers; a change counts once stages two and three agree
    logic [MST_SYNC_W-1:0] rawIn;
    logic [MST_SYNC_W-1:0] s1Q;
    logic [MST_SYNC_W-1:0] s2Q;
    logic [MST_SYNC_W-1:0] s3Q;
    logic [MST_SYNC_W-1:0] stableQ;

    assign rawIn = {zeroCurrent, chopTrip, logic_supply_lockout, overTemp, sourceGateSupplyFault,
                    sinkGateSupplyFault, rectify_disable, decay_select, enableN, sleepN, resetN,
                    resolution_sel_hi, resolution_sel_lo, dir, step};

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s1Q     <= '0;
            s2Q     <= '0;
            s3Q     <= '0;
            stableQ <= '0;
        end else begin
            s1Q <= rawIn;
            s2Q <= s1Q;
            s3Q <= s2Q;
            for (int i = 0; i < MST_SYNC_W; i++) begin
                if (s2Q[i] == s3Q[i]) begin
                    stableQ[i] <= s3Q[i];
                end
            end
        end
    end

    logic       stepS;
    logic       dirS;
    logic       resLoS;
    logic       resHiS;
    logic       resetNS;
    logic       sleepNS;
    logic       enableNS;
    logic [1:0] decayS;
    logic       rectDisS;
    logic       sinkFaultS;
    logic       srcFaultS;
    logic       overTempS;
    logic       lockoutS;
    logic [1:0] tripS;
    logic [1:0] zeroS;

    assign {zeroS, tripS, lockoutS, overTempS, srcFaultS, sinkFaultS, rectDisS, decayS,
            enableNS, sleepNS, resetNS, resHiS, resLoS, dirS, stepS} = stableQ;

    // Translator held home by reset pin, sleep or logic supply lockout
    logic holdHome;
    logic outputsOn;
    logic stepPrevQ;
    logic stepRise;

    assign holdHome  = !resetNS || !sleepNS || lockoutS;
    assign outputsOn = !holdHome && !enableNS && !sinkFaultS && !srcFaultS && !overTempS;
    assign stepRise  = stepS && !stepPrevQ && !holdHome;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            stepPrevQ <= 1'b0;
        end else begin
            stepPrevQ <= stepS;
        end
    end

    // Position in sixteenth steps; resolution and direction sampled only on the edge
    logic [5:0] posQ;
    logic [5:0] posD;
    logic [5:0] inc;

    always_comb begin
        unique case ({resHiS, resLoS})
            2'b00: inc = MST_INC_FULL;
            2'b01: inc = MST_INC_HALF;
            2'b10: inc = MST_INC_QUARTER;
            2'b11: inc = MST_INC_SIXTEENTH;
        endcase
        posD = dirS ? 6'(posQ + inc) : 6'(posQ - inc);
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            posQ <= MST_HOME_POS;
        end else if (holdHome) begin
            posQ <= MST_HOME_POS;
        end else if (stepRise) begin
            posQ <= posD;
        end
    end

    // Phase 1 follows cosine, phase 2 sine of the electrical angle
    function automatic logic [8:0] mst_phase(input logic [5:0] p, input logic isCos);
        logic [4:0] r;
        logic       odd;
        logic       neg;
        r   = {1'b0, p[3:0]};
        odd = p[4] ^ isCos;
        neg = isCos ? (p[5] ^ p[4]) : p[5];
        return {!neg, mst_sine(odd ? 5'd16 - r : r)};
    endfunction : mst_phase

    logic [8:0] ph1Next;
    logic [8:0] ph2Next;

    assign ph1Next = mst_phase(holdHome ? MST_HOME_POS : posD, 1'b1);
    assign ph2Next = mst_phase(holdHome ? MST_HOME_POS : posD, 1'b0);

    mst_decay_t decayPick;
    mst_decay_t decay1Q;
    mst_decay_t decay2Q;

    always_comb begin
        unique case (decayS)
            2'b00:   decayPick = MST_DECAY_SLOW;
            2'b01:   decayPick = MST_DECAY_FAST;
            default: decayPick = MST_DECAY_MIXED;
        endcase
    end

    logic stepEventQ;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            levelPhase1    <= MST_HOME_LEVEL;
            levelPhase2    <= MST_HOME_LEVEL;
            polarityPhase1 <= 1'b1;
            polarityPhase2 <= 1'b1;
            decay1Q        <= MST_DECAY_MIXED;
            decay2Q        <= MST_DECAY_MIXED;
            stepEventQ     <= 1'b0;
        end else begin
            stepEventQ <= stepRise;
            if (holdHome) begin
                {polarityPhase1, levelPhase1} <= ph1Next;
                {polarityPhase2, levelPhase2} <= ph2Next;
                decay1Q                       <= MST_DECAY_MIXED;
                decay2Q                       <= MST_DECAY_MIXED;
            end else if (stepRise) begin
                {polarityPhase1, levelPhase1} <= ph1Next;
                {polarityPhase2, levelPhase2} <= ph2Next;
                decay1Q <= (ph1Next[7:0] < levelPhase1) ? decayPick : MST_DECAY_SLOW;
                decay2Q <= (ph2Next[7:0] < levelPhase2) ? decayPick : MST_DECAY_SLOW;
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            home         <= 1'b0;
            chargePumpEn <= 1'b0;
        end else begin
            // Next position, so the flag moves in the same cycle as the levels
            home         <= resetNS && !holdHome && ((stepRise ? posD : posQ) == MST_HOME_POS);
            chargePumpEn <= sleepNS;
        end
    end

    // Software-set timing counts
    logic [15:0] offCycQ;
    logic [15:0] blankCycQ;
    logic [15:0] fastCycQ;
    logic        apbAccess;

    assign apbAccess = psel && penable && !pready;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            offCycQ   <= 16'(OFF_CYC_DEFAULT);
            blankCycQ <= 16'(BLANK_CYC_DEFAULT);
            fastCycQ  <= 16'(FAST_CYC_DEFAULT);
        end else if (apbAccess && pwrite) begin
            unique case (paddr)
                MST_REG_OFF:   offCycQ   <= pwdata[15:0];
                MST_REG_BLANK: blankCycQ <= pwdata[15:0];
                MST_REG_FAST:  fastCycQ  <= pwdata[15:0];
                default: ;
            endcase
        end
    end

    // One wait state; the answer is always registered
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= apbAccess;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
            if (apbAccess) begin
                unique case (paddr)
                    MST_REG_OFF:    prdata <= {16'h0000, offCycQ};
                    MST_REG_BLANK:  prdata <= {16'h0000, blankCycQ};
                    MST_REG_FAST:   prdata <= {16'h0000, fastCycQ};
                    MST_REG_STATUS: prdata <= {3'h0, decay2Q, decay1Q, levelPhase2, levelPhase1,
                                               polarityPhase2, polarityPhase1, home, posQ};
                    default:        pslverr <= 1'b1;
                endcase
            end
        end
    end

    mst_chop_if chop1 ();
    mst_chop_if chop2 ();

    always_comb begin
        chop1.enable      = outputsOn;
        chop1.stepEvent   = stepEventQ;
        chop1.polarity    = polarityPhase1;
        chop1.tripRaw     = tripS[0];
        chop1.zeroCur     = zeroS[0];
        chop1.rectDisable = rectDisS;
        chop1.decay       = decay1Q;
        chop1.offCycles   = offCycQ;
        chop1.blankCycles = blankCycQ;
        chop1.fastCycles  = fastCycQ;
        chop2.enable      = outputsOn;
        chop2.stepEvent   = stepEventQ;
        chop2.polarity    = polarityPhase2;
        chop2.tripRaw     = tripS[1];
        chop2.zeroCur     = zeroS[1];
        chop2.rectDisable = rectDisS;
        chop2.decay       = decay2Q;
        chop2.offCycles   = offCycQ;
        chop2.blankCycles = blankCycQ;
        chop2.fastCycles  = fastCycQ;
    end

    mst_chopper uChop1 (
        .clk  (clk),
        .nrst (nrst),
        .cif  (chop1.chop)
    );

    mst_chopper uChop2 (
        .clk  (clk),
        .nrst (nrst),
        .cif  (chop2.chop)
    );

    assign gatesPhase1 = chop1.gates;
    assign gatesPhase2 = chop2.gates;

endmodule : mst_translator_top

// ==== mst_host_model.sv ====
`timescale 1ns/1ps
module mst_host_model #(
    parameter int WAKE_CYC = 300
) (
    input  wire logic       clk,
    input  wire logic       nrst,
    input  wire logic       sleepN,
    input  wire logic       go,
    input  wire logic       goDir,
    input  wire logic [1:0] goRes,
    output logic            step,
    output logic            dir,
    output logic            resolution_sel_lo,
    output logic            resolution_sel_hi,
    output logic            busy
);
    logic [9:0] wake_q;
    logic [3:0] cnt_q;
    logic       pend_q;

    // Scaled wake delay after sleep release
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) wake_q <= 10'h000;
        else if (!sleepN) wake_q <= 10'h000;
        else if (wake_q != 10'(WAKE_CYC)) wake_q <= wake_q + 10'h001;
    end

    // Step high 6 and low at least 7 cycles, well above the input sync time
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cnt_q  <= 4'h0;
            pend_q <= 1'b0;
        end else begin
            if (go) pend_q <= 1'b1;
            if (cnt_q != 4'h0) cnt_q <= (cnt_q == 4'hC) ? 4'h0 : cnt_q + 4'h1;
            else if (pend_q && wake_q == 10'(WAKE_CYC)) begin
                cnt_q  <= 4'h1;
                pend_q <= 1'b0;
            end
        end
    end

    // Levels change only while idle, so they stay put around each edge
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) {dir, resolution_sel_hi, resolution_sel_lo} <= 3'h4;
        else if (cnt_q == 4'h0) {dir, resolution_sel_hi, resolution_sel_lo} <= {goDir, goRes};
    end

    assign step = cnt_q != 4'h0 && cnt_q < 4'h7;
    assign busy = pend_q || go || cnt_q != 4'h0;
endmodule : mst_host_model

// ==== mst_translator_top_chk.sv ====
`timescale 1ns/1ps
module mst_translator_top_chk (
    input wire logic       clk,
    input wire logic       nrst,
    input wire logic       psel,
    input wire logic       penable,
    input wire logic       pready,
    input wire logic       pslverr,
    input wire logic       step,
    input wire logic       resetN,
    input wire logic       sleepN,
    input wire logic       enableN,
    input wire logic       sinkGateSupplyFault,
    input wire logic       sourceGateSupplyFault,
    input wire logic       overTemp,
    input wire logic       logic_supply_lockout,
    input wire logic [3:0] gatesPhase1,
    input wire logic [3:0] gatesPhase2,
    input wire logic [7:0] levelPhase1,
    input wire logic [7:0] levelPhase2,
    input wire logic       polarityPhase1,
    input wire logic       polarityPhase2,
    input wire logic       chargePumpEn,
    input wire logic       home
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    wire gOff = gatesPhase1 == 4'h0 && gatesPhase2 == 4'h0;
    wire atHome = levelPhase1 == 8'hB4 && levelPhase2 == 8'hB4 && polarityPhase1 && polarityPhase2;
    wire run = resetN && sleepN && !logic_supply_lockout;

    rst_hold_a: assert property (!resetN [*6] |-> gOff && !home && atHome)
        else $error("reset pin hold broken");
    en_off_a: assert property (enableN [*6] |-> gOff)
        else $error("bridge on while disabled");
    reg_fault_a: assert property (sinkGateSupplyFault [*6] |-> gOff)
        else $error("bridge on with sink supply fault");
    hot_off_a: assert property ((overTemp || sourceGateSupplyFault) [*6] |-> gOff)
        else $error("bridge on with fault");
    lock_home_a: assert property (logic_supply_lockout [*6] |-> gOff && atHome && !home)
        else $error("lockout not home");
    sleep_off_a: assert property (!sleepN [*6] |-> gOff && !chargePumpEn && !home)
        else $error("sleep left outputs on");
    home_pos_a: assert property (home |-> atHome)
        else $error("home flag away from home");
    step_only_a: assert property ((run && !step) [*8] |-> $stable(levelPhase1) && $stable(levelPhase2))
        else $error("level moved without step");
    apb_answer_a: assert property (psel && penable && !pready |=> pready ##1 !pready)
        else $error("bus answer late");
endmodule : mst_translator_top_chk

bind mst_translator_top mst_translator_top_chk u_chk (.*);

// ==== mst_tb.sv ====
`timescale 1ns/1ps
module tb;
    logic        clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, e, busy;
    logic [7:0]  paddr = 8'h00, levelPhase1, levelPhase2;
    logic [31:0] pwdata = 32'h0000_0000, prdata, r;
    logic        pready, pslverr, step, dir, resolution_sel_lo, resolution_sel_hi;
    logic        resetN = 1, sleepN = 1, enableN = 0, rectify_disable = 1, overTemp = 0;
    logic        sinkGateSupplyFault = 0, sourceGateSupplyFault = 0, logic_supply_lockout = 0;
    logic        go = 0, goDir = 1, polarityPhase1, polarityPhase2, chargePumpEn, home;
    logic [1:0]  decay_select = 2'h2, chopTrip = 2'h0, zeroCurrent = 2'h0, goRes = 2'h0;
    logic [3:0]  gatesPhase1, gatesPhase2;
    int          bad_count = 0, comparisons = 0, cycles = 0;

    mst_translator_top #(.OFF_CYC_DEFAULT(40), .FAST_CYC_DEFAULT(10), .BLANK_CYC_DEFAULT(4)) dut (.*);
    mst_host_model #(.WAKE_CYC(300)) host (.*);

    initial forever #2 clk = ~clk;
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            bad_count++;
            report_and_stop();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // Request held until pready is seen high at an edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk);
        penable <= 1;
        do @(posedge clk); while (pready !== 1'b1);
        r = prdata; e = pslverr;
        psel <= 0; penable <= 0;
    endtask : apb
    task automatic pos(input logic [5:0] p);
        apb(0, 8'h0C, 32'h0000_0000);
        chk(r[5:0], p);
    endtask : pos
    task automatic st(input logic d, input logic [1:0] rs);
        @(posedge clk);
        goDir <= d; goRes <= rs; go <= 1;
        @(posedge clk);
        go <= 0;
        do @(posedge clk); while (busy);
        repeat (4) @(posedge clk);
    endtask : st
    task automatic waitg(input logic [3:0] g);
        int n;
        n = 0;
        while (gatesPhase1 !== g && n < 300) begin
            @(posedge clk);
            n++;
        end
        chk(gatesPhase1, g);
    endtask : waitg
    task report_and_stop;
        if (bad_count == 0 && comparisons > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : report_and_stop

    task t_regs;
        apb(0, 8'h00, 0); chk(r, 32'h0000_0028);
        apb(1, 8'h00, 32'h1234_0030); apb(0, 8'h00, 0); chk(r, 32'h0000_0030);
        apb(0, 8'h10, 0); chk(e, 1'h1); chk(r, 32'h0000_0000);
        apb(1, 8'h0C, 32'h0000_0000); apb(0, 8'h0C, 0); chk(r, {3'h0, 4'hA, 16'hB4B4, 3'h7, 6'h08});
    endtask : t_regs
    task t_chop;
        waitg(4'h9); chk(gatesPhase2, 4'h9);
        chopTrip <= 2'h1;
        waitg(4'h0);
        chopTrip <= 2'h0;
        waitg(4'h9);
        rectify_disable <= 0; chopTrip <= 2'h1;
        waitg(4'h6);
        waitg(4'h5);
        zeroCurrent <= 2'h1;
        waitg(4'h1);
        chopTrip <= 2'h0; zeroCurrent <= 2'h0; rectify_disable <= 1;
        waitg(4'h9);
    endtask : t_chop
    task t_steps;
        logic [5:0] inc [4] = '{6'h10, 6'h08, 6'h04, 6'h01};
        for (int i = 0; i < 4; i++) begin
            st(1, i[1:0]); pos(6'h08 + inc[i]); chk(home, 0);
            st(0, i[1:0]); pos(6'h08); chk(home, 1);
        end
        st(0, 0); pos(6'h38); st(0, 0); pos(6'h28); st(0, 0); st(0, 0); pos(6'h08);
    endtask : t_steps
    task t_decay;
        for (int c = 0; c < 3; c++) begin
            decay_select <= c[1:0];
            st(1, 3); apb(0, 8'h0C, 0); chk(r[28:25], {2'h0, c[1:0]});
            st(0, 3); apb(0, 8'h0C, 0); chk(r[28:25], {c[1:0], 2'h0});
        end
    endtask : t_decay
    task t_pins;
        st(1, 0); goDir <= 0; goRes <= 3;
        repeat (20) @(posedge clk);
        pos(6'h18);
        resetN <= 0; repeat (8) @(posedge clk); pos(6'h08);
        st(1, 0); pos(6'h08); resetN <= 1;
        enableN <= 1; overTemp <= 1; sinkGateSupplyFault <= 1;
        st(1, 3); pos(6'h09);
        enableN <= 0; overTemp <= 0; sinkGateSupplyFault <= 0;
        logic_supply_lockout <= 1; repeat (8) @(posedge clk); pos(6'h08);
        logic_supply_lockout <= 0; st(1, 1);
        sleepN <= 0; repeat (8) @(posedge clk); pos(6'h08); chk(chargePumpEn, 0);
        sleepN <= 1; st(1, 2); pos(6'h0C); chk(chargePumpEn, 1);
    endtask : t_pins

    initial begin
        repeat (10) @(posedge clk);
        chk({home, gatesPhase1, gatesPhase2, levelPhase1, levelPhase2, polarityPhase1, polarityPhase2}, 32'h0002_D2D3);
        nrst <= 1;
        repeat (20) @(posedge clk);
        chk(home, 1);
        t_regs(); t_chop(); t_steps(); t_decay(); t_pins();
        report_and_stop();
    end
endmodule : tb
